/* hw/serializer_cfg_map.svh */
/*
 register offsets, field positions, reset values for the serializer configuration/status bank.
 assumes byte-wide registers at the printed offsets on a plain register port.
*/
`ifndef SERIALIZER_CFG_MAP_SVH
`define SERIALIZER_CFG_MAP_SVH

`define OFS_RSVD_CFG_A     8'h06
`define OFS_RSVD_CFG_B     8'h07
`define OFS_CABLE_FAULT    8'h08
`define OFS_RSVD_STAT_A    8'h09
`define OFS_RSVD_STAT_B    8'h0A
`define OFS_RSVD_STAT_C    8'h0B
`define OFS_RSVD_CFG_C     8'h0C
`define OFS_OUT_SYNC_POL   8'h0D
`define OFS_DE_POL         8'h0E
`define OFS_XLATE_SRC_A    8'h0F
`define OFS_XLATE_DST_A    8'h10
`define OFS_XLATE_SRC_B    8'h11
`define OFS_XLATE_DST_B    8'h12
`define OFS_IRQ_STATUS     8'h20
`define OFS_IRQ_ENABLE     8'h21
`define OFS_IRQ_CLEAR      8'h22

`define RST_RSVD_CFG_A     8'h40
`define RST_RSVD_CFG_B     8'h22
`define RST_RSVD_CFG_C     8'h20
`define RST_ZERO           8'h00
`define WIRE_NORMAL        2'h2

`define BIT_GP_LEVEL       7
`define BIT_VSYNC_FLIP     6
`define BIT_HSYNC_FLIP     5
`define BIT_DE_FLIP        7
`define NEG_FAULT_HI       3
`define NEG_FAULT_LO       2
`define POS_FAULT_HI       1
`define POS_FAULT_LO       0
`define ADDR_HI            7
`define ADDR_LO            1

`define IRQ_BIT_NEG        0
`define IRQ_BIT_POS        1
`define IRQ_WIDTH          2

`endif

/* hw/serializer_cfg_pkg.sv */
/*
 types shared by the serializer configuration/status bank.
 assumes nothing beyond the map header.
*/
package serializer_cfg_pkg;
    typedef logic [1:0] wire_state_t;
    typedef logic [6:0] i2c_addr_t;
    typedef logic [7:0] reg_byte_t;
endpackage : serializer_cfg_pkg

/* hw/serializer_config_status_regs.sv */
/*
 configuration and status register bank of a serial video-link transmitter:
 cable-fault status, general-purpose output, sync/enable polarity flips, and
 an I2C address translator with two entries.
 assumes one 10 MHz clock, synchronous active-high reset, a plain register
 port with read data one cycle after the read strobe, and fault codes
 already synchronous to mclk.
*/
// Contract
// - negative wire state read-only 2-bit field, codes 00/01/10/11, resets to normal.
// - positive wire state in low two bits, same codes, resets to normal.
// - general-purpose pin follows output-level bit; bit resets to 0.
// - vsync inverted when its flip bit is set; bit resets to 0.
// - hsync inverted when its flip bit is set; bit resets to 0.
// - data-enable inverted when top-bit flip is set; resets to 0.
// - translation source A in bits 7:1, resets zero, bit 0 reads 0.
// - translation destination A in bits 7:1, resets zero, bit 0 reserved.
// - translation source B in bits 7:1, resets to zeros.
// - translation destination B in next register bits 7:1, resets zero.
`include "serializer_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module serializer_config_status_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // cable monitor from analog driver
    input wire serializer_cfg_pkg::wire_state_t neg_wire_fault,
    input wire serializer_cfg_pkg::wire_state_t pos_wire_fault,
    // video inputs and conditioned outputs
    input wire logic vsync_in,
    input wire logic hsync_in,
    input wire logic de_in,
    output logic vsync_out,
    output logic hsync_out,
    output logic de_out,
    // general-purpose output
    output logic gpo,
    // address translation
    input wire serializer_cfg_pkg::i2c_addr_t i2c_addr_in,
    input wire logic i2c_addr_valid,
    output serializer_cfg_pkg::i2c_addr_t i2c_addr_out,
    output logic i2c_addr_out_valid,
    // interrupt
    output logic irq
);
    import serializer_cfg_pkg::*;

    wire_state_t neg_fault_r;
    wire_state_t pos_fault_r;
    logic gp_output_level_r;
    logic vsync_polarity_flip_r;
    logic hsync_polarity_flip_r;
    logic data_enable_polarity_flip_r;
    i2c_addr_t xlate_src_a_r;
    i2c_addr_t xlate_dst_a_r;
    i2c_addr_t xlate_src_b_r;
    i2c_addr_t xlate_dst_b_r;
    logic [`IRQ_WIDTH-1:0] irq_status_r;
    logic [`IRQ_WIDTH-1:0] irq_enable_r;
    reg_byte_t rdata_nxt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // fault codes are registered so status reads see a stable value; events compare the raw input code against it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            neg_fault_r <= `WIRE_NORMAL;
            pos_fault_r <= `WIRE_NORMAL;
        end else begin
            neg_fault_r <= neg_wire_fault;
            pos_fault_r <= pos_wire_fault;
        end
    end

    // output-level and sync polarity register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gp_output_level_r <= 1'b0;
            vsync_polarity_flip_r <= 1'b0;
            hsync_polarity_flip_r <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `OFS_OUT_SYNC_POL)) begin
            gp_output_level_r <= reg_wdata[`BIT_GP_LEVEL];
            vsync_polarity_flip_r <= reg_wdata[`BIT_VSYNC_FLIP];
            hsync_polarity_flip_r <= reg_wdata[`BIT_HSYNC_FLIP];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_enable_polarity_flip_r <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `OFS_DE_POL)) begin
            data_enable_polarity_flip_r <= reg_wdata[`BIT_DE_FLIP];
        end
    end

    // translation table; bit 0 of each write is dropped, it always reads 0
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            xlate_src_a_r <= 7'h00;
            xlate_dst_a_r <= 7'h00;
            xlate_src_b_r <= 7'h00;
            xlate_dst_b_r <= 7'h00;
        end else if (reg_wr) begin
            if (hit(reg_addr, `OFS_XLATE_SRC_A)) begin
                xlate_src_a_r <= reg_wdata[`ADDR_HI:`ADDR_LO];
            end
            if (hit(reg_addr, `OFS_XLATE_DST_A)) begin
                xlate_dst_a_r <= reg_wdata[`ADDR_HI:`ADDR_LO];
            end
            if (hit(reg_addr, `OFS_XLATE_SRC_B)) begin
                xlate_src_b_r <= reg_wdata[`ADDR_HI:`ADDR_LO];
            end
            if (hit(reg_addr, `OFS_XLATE_DST_B)) begin
                xlate_dst_b_r <= reg_wdata[`ADDR_HI:`ADDR_LO];
            end
        end
    end

    // pins: one register stage for every conditioned signal
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gpo <= 1'b0;
            vsync_out <= 1'b0;
            hsync_out <= 1'b0;
            de_out <= 1'b0;
        end else begin
            gpo <= gp_output_level_r;
            vsync_out <= vsync_in ^ vsync_polarity_flip_r;
            hsync_out <= hsync_in ^ hsync_polarity_flip_r;
            de_out <= de_in ^ data_enable_polarity_flip_r;
        end
    end

    // entry A wins if both sources match; a zero source disables its entry
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            i2c_addr_out <= 7'h00;
            i2c_addr_out_valid <= 1'b0;
        end else begin
            i2c_addr_out_valid <= i2c_addr_valid;
            if (i2c_addr_valid) begin
                if (xlate_src_a_r != 7'h00 && i2c_addr_in == xlate_src_a_r) begin
                    i2c_addr_out <= xlate_dst_a_r;
                end else if (xlate_src_b_r != 7'h00 && i2c_addr_in == xlate_src_b_r) begin
                    i2c_addr_out <= xlate_dst_b_r;
                end else begin
                    i2c_addr_out <= i2c_addr_in;
                end
            end
        end
    end

    // sticky fault bits: set on a change of wire state into a fault; set beats clear
    logic [`IRQ_WIDTH-1:0] fault_new;
    assign fault_new[`IRQ_BIT_NEG] = (neg_wire_fault != `WIRE_NORMAL) && (neg_wire_fault != neg_fault_r);
    assign fault_new[`IRQ_BIT_POS] = (pos_wire_fault != `WIRE_NORMAL) && (pos_wire_fault != pos_fault_r);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~((reg_wr && hit(reg_addr, `OFS_IRQ_CLEAR)) ?
                reg_wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) | fault_new;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_enable_r <= '0;
        end else if (reg_wr && hit(reg_addr, `OFS_IRQ_ENABLE)) begin
            irq_enable_r <= reg_wdata[`IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_enable_r & irq_status_r);
        end
    end

    // read mux; reserved words return their defaults, unmapped offsets read zero
    always_comb begin
        rdata_nxt = `RST_ZERO;
        unique case (reg_addr)
            `OFS_RSVD_CFG_A: rdata_nxt = `RST_RSVD_CFG_A;
            `OFS_RSVD_CFG_B: rdata_nxt = `RST_RSVD_CFG_B;
            `OFS_RSVD_CFG_C: rdata_nxt = `RST_RSVD_CFG_C;
            `OFS_CABLE_FAULT: rdata_nxt = {4'h0, neg_fault_r, pos_fault_r};
            `OFS_OUT_SYNC_POL: rdata_nxt = {gp_output_level_r, vsync_polarity_flip_r, hsync_polarity_flip_r, 5'h00};
            `OFS_DE_POL: rdata_nxt = {data_enable_polarity_flip_r, 7'h00};
            `OFS_XLATE_SRC_A: rdata_nxt = {xlate_src_a_r, 1'b0};
            `OFS_XLATE_DST_A: rdata_nxt = {xlate_dst_a_r, 1'b0};
            `OFS_XLATE_SRC_B: rdata_nxt = {xlate_src_b_r, 1'b0};
            `OFS_XLATE_DST_B: rdata_nxt = {xlate_dst_b_r, 1'b0};
            `OFS_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
            `OFS_IRQ_ENABLE: rdata_nxt = {6'h00, irq_enable_r};
            default: rdata_nxt = `RST_ZERO;
        endcase
    end

    // writes to reserved and read-only offsets are dropped in hardware
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= `RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= `RST_ZERO;
        end
    end
endmodule : serializer_config_status_regs

`default_nettype wire

/* tb/serializer_regs_chk_sva.sv */
/*
 port-level checker for the serializer register bank.
 assumes it is bound into serializer_config_status_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module serializer_regs_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // video and general-purpose output
    input wire logic vsync_in,
    input wire logic hsync_in,
    input wire logic de_in,
    input wire logic vsync_out,
    input wire logic hsync_out,
    input wire logic de_out,
    input wire logic gpo,
    // translation and interrupt
    input wire serializer_cfg_pkg::i2c_addr_t i2c_addr_in,
    input wire logic i2c_addr_valid,
    input wire serializer_cfg_pkg::i2c_addr_t i2c_addr_out,
    input wire logic i2c_addr_out_valid,
    input wire logic irq
);
    import serializer_cfg_pkg::*;
    // flip and enable bits are not visible at the ports, so mirror them from writes
    logic [1:0] sync_r;
    logic de_r;
    logic [1:0] en_r;
    logic live_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_r <= 2'h0;
            de_r <= 1'b0;
            en_r <= 2'h0;
            live_r <= 1'b0;
        end else begin
            live_r <= 1'b1;
            if (reg_wr && reg_addr == 8'h0D) sync_r <= reg_wdata[6:5];
            if (reg_wr && reg_addr == 8'h0E) de_r <= reg_wdata[7];
            if (reg_wr && reg_addr == 8'h21) en_r <= reg_wdata[1:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_gpo_wr;
        reg_wr && reg_addr == 8'h0D;
    endsequence
    sequence s_addr_rd;
        reg_rd && reg_addr >= 8'h0F && reg_addr <= 8'h12;
    endsequence
    chk_gpo_level: assert property (s_gpo_wr |-> ##2 gpo == $past(reg_wdata[7], 2))
        else $error("gpo does not follow level bit");
    chk_vsync_flip: assert property (live_r |-> vsync_out == ($past(vsync_in) ^ $past(sync_r[1])))
        else $error("vsync polarity wrong");
    chk_hsync_flip: assert property (live_r |-> hsync_out == ($past(hsync_in) ^ $past(sync_r[0])))
        else $error("hsync polarity wrong");
    chk_de_flip: assert property (live_r |-> de_out == ($past(de_in) ^ $past(de_r)))
        else $error("data enable polarity wrong");
    chk_addr_lsb: assert property (s_addr_rd |=> reg_rdata[0] == 1'b0)
        else $error("translator low bit not zero");
    chk_xlate_pulse: assert property (live_r |-> i2c_addr_out_valid == $past(i2c_addr_valid))
        else $error("translated valid misplaced");
    chk_xlate_zero: assert property (i2c_addr_valid && i2c_addr_in == 7'h00 |=> i2c_addr_out == 7'h00)
        else $error("zero address altered");
    chk_irq_masked: assert property (irq |-> $past(|en_r))
        else $error("interrupt while all disabled");
endmodule : serializer_regs_chk
bind serializer_config_status_regs serializer_regs_chk i_chk (.*);
`default_nettype wire

/* tb/serializer_config_status_regs_bench.sv */
/*
 self-checking bench for the serializer register bank.
 assumes the map header and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module serializer_config_status_regs_bench;
    import serializer_cfg_pkg::*;
    logic mclk, sys_rst, reg_wr, reg_rd, vsync_in, hsync_in, de_in, i2c_addr_valid;
    logic vsync_out, hsync_out, de_out, gpo, i2c_addr_out_valid, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    wire_state_t neg_wire_fault, pos_wire_fault;
    i2c_addr_t i2c_addr_in, i2c_addr_out;
    int error_cnt, total_checks;
    serializer_config_status_regs i_dut (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .neg_wire_fault(neg_wire_fault),
        .pos_wire_fault(pos_wire_fault),
        .vsync_in(vsync_in),
        .hsync_in(hsync_in),
        .de_in(de_in),
        .vsync_out(vsync_out),
        .hsync_out(hsync_out),
        .de_out(de_out),
        .gpo(gpo),
        .i2c_addr_in(i2c_addr_in),
        .i2c_addr_valid(i2c_addr_valid),
        .i2c_addr_out(i2c_addr_out),
        .i2c_addr_out_valid(i2c_addr_out_valid),
        .irq(irq)
    );
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #10 chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    task stop_test;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task t_defaults;
        for (int a = 6; a <= 18; a++) begin
            rd(8'(a), a == 6 ? 8'h40 : a == 7 ? 8'h22 : a == 8 ? 8'h0A : a == 12 ? 8'h20 : 8'h00);
        end
        rd(8'h30, 8'h00);
        // read-only and reserved places must ignore writes
        wr(8'h08, 8'hFF);
        wr(8'h06, 8'h00);
        rd(8'h08, 8'h0A);
        rd(8'h06, 8'h40);
    endtask : t_defaults
    task t_cable;
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            neg_wire_fault <= 2'(c);
            pos_wire_fault <= 2'(3 - c);
            rd(8'h08, {4'h0, 2'(c), 2'(3 - c)});
        end
        rd(8'h20, 8'h03);
        wr(8'h21, 8'h03);
        @(posedge mclk);
        #10 chk("irq", 8'h01, {7'h0, irq});
        wr(8'h21, 8'h00);
        @(posedge mclk);
        #10 chk("irq", 8'h00, {7'h0, irq});
        wr(8'h21, 8'h03);
        wr(8'h22, 8'h03);
        rd(8'h20, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        neg_wire_fault <= 2'h2;
        pos_wire_fault <= 2'h2;
    endtask : t_cable
    task t_video;
        for (int m = 0; m < 2; m++) begin
            wr(8'h0D, m ? 8'hE0 : 8'h00);
            wr(8'h0E, m ? 8'h80 : 8'h00);
            rd(8'h0D, m ? 8'hE0 : 8'h00);
            chk("gpo", 8'(m), {7'h0, gpo});
            for (int v = 0; v < 8; v++) begin
                @(posedge mclk);
                {vsync_in, hsync_in, de_in} <= 3'(v);
                @(posedge mclk);
                #10 chk("video", {5'h0, 3'(v) ^ {3{m[0]}}}, {5'h0, vsync_out, hsync_out, de_out});
            end
        end
    endtask : t_video
    task xl(input i2c_addr_t a, input i2c_addr_t exp);
        @(posedge mclk);
        i2c_addr_valid <= 1'b1;
        i2c_addr_in <= a;
        @(posedge mclk);
        i2c_addr_valid <= 1'b0;
        #10 chk("i2c_addr_out", {1'b0, exp}, {i2c_addr_out_valid, i2c_addr_out} ^ 8'h80);
    endtask : xl
    task t_xlate;
        wr(8'h0F, 8'h43);
        wr(8'h10, 8'h8A);
        wr(8'h11, 8'h66);
        wr(8'h12, 8'hB4);
        rd(8'h0F, 8'h42);
        rd(8'h12, 8'hB4);
        xl(7'h21, 7'h45);
        xl(7'h33, 7'h5A);
        xl(7'h10, 7'h10);
        xl(7'h00, 7'h00);
        wr(8'h0F, 8'h00);
        xl(7'h21, 7'h21);
    endtask : t_xlate
    initial begin
        {sys_rst, reg_wr, reg_rd, vsync_in, hsync_in, de_in, i2c_addr_valid} = 7'h40;
        {reg_addr, reg_wdata, i2c_addr_in} = 23'h0;
        neg_wire_fault = 2'h2;
        pos_wire_fault = 2'h2;
        error_cnt = 0;
        total_checks = 0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        t_defaults();
        t_cable();
        t_video();
        t_xlate();
        stop_test();
    end
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
endmodule : serializer_config_status_regs_bench
`default_nettype wire
